// ==== rtl/rlis_line_input.sv ====
// Receive line input stage: serial or byte source selection, word assembly, buffering
//
// Operation
// - With the interface select high, the stream comes from the differential serial data and clock.
// - In STS-1 with serial selected, a single-ended serial data line with its own clock may be the source.
// - With the interface select low, the stream comes from the byte clock, byte bus and frame strobe.
// - The byte bus and frame strobe are sampled on each rising edge of the byte clock.
// - The top bus line carries bit 1 of each word, the first bit on the line.
// - The bottom bus line carries bit 8 of each word, the last bit on the line.
// - The input handles STS-1 streams at 51.84 Mbit/s and STS-3 streams at 155.52 Mbit/s.
// - Receive interface and rate settings are independent of the transmit side.
// - In differential serial mode the line clock is divided by eight to give the derived byte clock.
`timescale 1ns/100ps
`default_nettype none
module rlis_line_input
   import rlis_pkg::*;
#(
   parameter int unsigned WORD_WIDTH = BYTE_WIDTH
) (
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  rxInterfaceSelect,
   input  wire logic                  rxRateSts3,
   input  wire logic                  ttlSerialSelect,
   input  wire logic                  diffRxClock,
   input  wire logic                  diffRxData,
   input  wire logic                  ttlSerialRxClock,
   input  wire logic                  ttlSerialRxLine,
   input  wire logic                  byteRxClock,
   input  wire logic [WORD_WIDTH-1:0] byteRxBus,
   input  wire logic                  rxFramePosition,
   output var  logic                  derivedRxByteClock,
   output var  rlis_word_t            rxWord,
   output var  logic                  rxWordValid,
   input  wire logic                  rxWordReady,
   output var  logic                  rxOverrun,
   output var  rlis_source_t          rxSource
);

   // Ratio of line rate to byte rate for both rates
   // Both ratios must equal the divider, since one counter serves
   // either rate and the rate pin only blocks the single-ended line
   // and tags the words that leave the buffer
   localparam longint unsigned STS1_RATIO = STS1_LINE_BPS / STS1_BYTE_HZ;
   localparam longint unsigned STS3_RATIO = STS3_LINE_BPS / STS3_BYTE_HZ;

   // Two-stage synchronisers for every pin input
   // Every pin, line clocks included, is asynchronous to the system clock,
   // so no logic reads a pin before its second stage
   logic [SYNC_DEPTH-1:0] selSync;
   logic [SYNC_DEPTH-1:0] rateSync;
   logic [SYNC_DEPTH-1:0] ttlSelSync;
   logic [SYNC_DEPTH-1:0] diffClkSync;
   logic [SYNC_DEPTH-1:0] diffDatSync;
   logic [SYNC_DEPTH-1:0] ttlClkSync;
   logic [SYNC_DEPTH-1:0] ttlDatSync;
   logic [SYNC_DEPTH-1:0] byteClkSync;
   logic [SYNC_DEPTH-1:0] framePosSync;
   logic [WORD_WIDTH-1:0] busMeta;
   logic [WORD_WIDTH-1:0] busSync;

   // Delayed copies for edge detection, read only after the second stage
   // Reset low matches the idle level of every line clock, so release
   // of reset never shows a false rising edge
   logic diffClkLast;
   logic ttlClkLast;
   logic byteClkLast;

   // Serial assembly state
   // Counter and shift register realign together on any source change
   // and run only while a serial source is chosen
   rlis_source_t          source;
   rlis_source_t          next_source;
   logic [WORD_WIDTH-1:0] shiftReg;
   logic [DIV_WIDTH-1:0]  bitCount;
   logic                  divClock;

   // Word handed to the buffer
   // The pending stage holds each word for one cycle only; a line cannot
   // wait, so a word that meets a full buffer is dropped and flagged
   rlis_word_t            pendWord;
   logic                  pendValid;
   rlis_word_t            next_pendWord;
   logic                  next_pendValid;
   logic                  bufReady;
   logic                  overrun;

   // Shift one serial bit in below the earlier ones
   function automatic logic [WORD_WIDTH-1:0] shiftIn(
      input logic [WORD_WIDTH-1:0] word,
      input logic                  bitIn
   );
      shiftIn = {word[WORD_WIDTH-2:0], bitIn};
   endfunction : shiftIn

   // Rising edge of a synchronised clock
   function automatic logic riseOf(input logic now, input logic last);
      riseOf = now & ~last;
   endfunction : riseOf

   // Synchroniser chains
   // The byte bus and the frame strobe pass the same depth as the byte
   // clock, so a sampled edge and its data stay aligned
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         selSync      <= '0;
         rateSync     <= '0;
         ttlSelSync   <= '0;
         diffClkSync  <= '0;
         diffDatSync  <= '0;
         ttlClkSync   <= '0;
         ttlDatSync   <= '0;
         byteClkSync  <= '0;
         framePosSync <= '0;
         busMeta      <= '0;
         busSync      <= '0;
      end else begin
         selSync      <= {selSync[0], rxInterfaceSelect};
         rateSync     <= {rateSync[0], rxRateSts3};
         ttlSelSync   <= {ttlSelSync[0], ttlSerialSelect};
         diffClkSync  <= {diffClkSync[0], diffRxClock};
         diffDatSync  <= {diffDatSync[0], diffRxData};
         ttlClkSync   <= {ttlClkSync[0], ttlSerialRxClock};
         ttlDatSync   <= {ttlDatSync[0], ttlSerialRxLine};
         byteClkSync  <= {byteClkSync[0], byteRxClock};
         framePosSync <= {framePosSync[0], rxFramePosition};
         busMeta      <= byteRxBus;
         busSync      <= busMeta;
      end
   end

   // Edge history taken from the second stages only
   // An edge is a high second stage after a low copy of the same stage
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         diffClkLast <= 1'b0;
         ttlClkLast  <= 1'b0;
         byteClkLast <= 1'b0;
      end else begin
         diffClkLast <= diffClkSync[1];
         ttlClkLast  <= ttlClkSync[1];
         byteClkLast <= byteClkSync[1];
      end
   end

   // Settled selection levels; nothing here looks at the transmit side
   // Selection pins are meant to be tied; a change in service is still
   // handled by realigning the serial assembly
   wire selSerial = selSync[1];
   wire selSts3   = rateSync[1];
   wire selTtl    = ttlSelSync[1] & ~selSts3;      // Single-ended line only in STS-1

   // Source decode
   // The single-ended request is ignored at the high rate
   // and the differential line then serves
   always_comb begin
      if (!selSerial) begin
         next_source = SRC_BYTE;
      end else if (selTtl) begin
         next_source = SRC_TTL;
      end else begin
         next_source = SRC_PECL;
      end
   end

   // Flags the cycle in which the settled selection leaves the registered source
   wire sourceChange = (next_source != source);

   // Bit strobe and bit value of whichever serial line is active
   // The line clocks are oversampled, so each must stay high and low for
   // at least two system clocks to give one clean strobe per bit
   wire diffRise = riseOf(diffClkSync[1], diffClkLast);
   wire ttlRise  = riseOf(ttlClkSync[1], ttlClkLast);
   wire byteRise = riseOf(byteClkSync[1], byteClkLast);
   wire bitStrobe = (source == SRC_PECL) ? diffRise :
                    (source == SRC_TTL)  ? ttlRise  : 1'b0;
   wire bitValue  = (source == SRC_PECL) ? diffDatSync[1] : ttlDatSync[1];
   wire byteDone  = bitStrobe & (bitCount == DIV_LAST);
   wire [WORD_WIDTH-1:0] nextShift = shiftIn(shiftReg, bitValue);

   // Source register follows the settled selection
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         source <= SRC_BYTE;
      end else begin
         source <= next_source;
      end
   end

   // Bit counter doubles as the divide-by-eight for the derived byte clock
   // A partial byte is discarded on a source change; the first full byte
   // after it starts with the counter at zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bitCount <= DIV_RESET;
         shiftReg <= WORD_RESET;
      end else if (sourceChange || source == SRC_BYTE) begin
         bitCount <= DIV_RESET;                    // Realign on any change of source
         shiftReg <= WORD_RESET;
      end else if (bitStrobe) begin
         bitCount <= bitCount + 3'h1;              // Wraps after eight bits
         shiftReg <= nextShift;                    // First bit ends at the top
      end
   end

   // Derived byte clock: high for the first half of each byte, low for the second
   // It rises on the first bit after a realign and again at every byte end,
   // and falls at the fourth bit; with the line clock stopped it holds its level,
   // and a realign on a source change may cut a high phase short
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         divClock <= 1'b0;
      end else if (source == SRC_BYTE || sourceChange) begin
         divClock <= 1'b0;
      end else if (bitStrobe) begin
         divClock <= (bitCount + 3'h1) < DIV_WIDTH'(DIV_HALF);
      end
   end

   // Word capture: byte bus on byte clock rise, or a completed serial byte
   // A serial word never carries a frame strobe; framing of serial
   // streams is left to the framer downstream
   always_comb begin
      next_pendWord  = pendWord;
      next_pendValid = 1'b0;
      if (sourceChange) begin
         next_pendValid = 1'b0;
      end else if (source == SRC_BYTE && byteRise) begin
         next_pendWord.data       = busSync;         // Top line is first bit
         next_pendWord.framePos   = framePosSync[1];
         next_pendWord.fromSerial = 1'b0;
         next_pendWord.rateSts3   = selSts3;
         next_pendValid           = 1'b1;            // Passed on still scrambled
      end else if (source != SRC_BYTE && byteDone) begin
         next_pendWord.data       = nextShift;
         next_pendWord.framePos   = 1'b0;
         next_pendWord.fromSerial = 1'b1;
         next_pendWord.rateSts3   = selSts3;
         next_pendValid           = 1'b1;
      end
   end

   // Pending word register and overrun detection
   // The overrun flag is a one-cycle pulse per dropped word, so a counter
   // downstream can total the losses
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pendWord  <= '0;
         pendValid <= 1'b0;
         overrun   <= 1'b0;
      end else begin
         pendWord  <= next_pendWord;
         pendValid <= next_pendValid;
         overrun   <= pendValid & ~bufReady;       // A line cannot be stalled
      end
   end

   // Two-entry buffer absorbs stalls by the receiver
   // Its ready comes from a flip-flop, so no path runs combinationally
   // from the receiver's ready back towards the line
   rlis_skid_buffer #(
      .WIDTH (WORD_BITS)
   ) u_buffer (
      .clock    (clock),
      .rst_b    (rst_b),
      .inData   (pendWord),
      .inValid  (pendValid),
      .inReady  (bufReady),
      .outData  (rxWord),
      .outValid (rxWordValid),
      .outReady (rxWordReady)
   );

   // Registered status outputs
   // One more stage keeps every top output straight from a flip-flop
   // and delays the source report by one cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         derivedRxByteClock <= 1'b0;
         rxOverrun          <= 1'b0;
         rxSource           <= SRC_BYTE;
      end else begin
         derivedRxByteClock <= divClock;           // Looped back to the byte clock pin
         rxOverrun          <= overrun;
         rxSource           <= source;
      end
   end

   // Both rates divide to bytes by the same ratio
   // Checked once at start-up; a mismatch means the package constants disagree
   initial begin
      if (STS1_RATIO != DIV_RATIO || STS3_RATIO != DIV_RATIO) begin
         $error("Line to byte ratio differs from the divider");
      end
   end

endmodule : rlis_line_input
`default_nettype wire

// ==== rtl/rlis_pkg.sv ====
// Shared constants and types for the receive line input select block
package rlis_pkg;

   // Word and divider geometry
   localparam int unsigned BYTE_WIDTH  = 8;
   localparam int unsigned DIV_RATIO   = 8;
   localparam int unsigned DIV_HALF    = DIV_RATIO / 2;
   localparam int unsigned DIV_WIDTH   = 3;
   localparam int unsigned SYNC_DEPTH  = 2;

   // Line and byte rates in bit/s and Hz
   localparam longint unsigned STS1_LINE_BPS = 64'd51_840_000;
   localparam longint unsigned STS3_LINE_BPS = 64'd155_520_000;
   localparam longint unsigned STS1_BYTE_HZ  = 64'd6_480_000;
   localparam longint unsigned STS3_BYTE_HZ  = 64'd19_440_000;
   localparam longint unsigned CLOCK_HZ      = 64'd10_000_000;

   // Reset values
   localparam logic [BYTE_WIDTH-1:0] WORD_RESET = 8'h00;
   localparam logic [DIV_WIDTH-1:0]  DIV_RESET  = 3'h0;
   localparam logic [DIV_WIDTH-1:0]  DIV_LAST   = 3'h7;

   // Receive source in use
   typedef enum logic [1:0] {
      SRC_BYTE,
      SRC_PECL,
      SRC_TTL
   } rlis_source_t;

   // One received byte with its tags
   typedef struct packed {
      logic [BYTE_WIDTH-1:0] data;
      logic                  framePos;
      logic                  fromSerial;
      logic                  rateSts3;
   } rlis_word_t;

   localparam int unsigned WORD_BITS = $bits(rlis_word_t);

endpackage : rlis_pkg

// ==== rtl/rlis_skid_buffer.sv ====
// Two-entry buffer with a registered head, valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rlis_skid_buffer #(
   parameter int unsigned WIDTH = 11
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output var  logic             inReady,
   output var  logic [WIDTH-1:0] outData,
   output var  logic             outValid,
   input  wire logic             outReady
);

   logic [WIDTH-1:0] skidData;
   logic             skidValid;
   logic [WIDTH-1:0] next_outData;
   logic             next_outValid;
   logic [WIDTH-1:0] next_skidData;
   logic             next_skidValid;

   wire push = inValid & inReady;
   wire pop  = outValid & outReady;

   // Head refills from the skid entry first so order is kept
   always_comb begin
      next_outData   = outData;
      next_outValid  = outValid;
      next_skidData  = skidData;
      next_skidValid = skidValid;
      if (pop) begin
         if (skidValid) begin
            next_outData   = skidData;
            next_skidData  = inData;
            next_skidValid = push;
         end else begin
            next_outData  = inData;
            next_outValid = push;
         end
      end else if (push) begin
         if (!outValid) begin
            next_outData  = inData;
            next_outValid = 1'b1;
         end else begin
            next_skidData  = inData;
            next_skidValid = 1'b1;
         end
      end
   end

   // Storage and flags
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         outData   <= '0;
         outValid  <= 1'b0;
         skidData  <= '0;
         skidValid <= 1'b0;
         inReady   <= 1'b0;
      end else begin
         outData   <= next_outData;
         outValid  <= next_outValid;
         skidData  <= next_skidData;
         skidValid <= next_skidValid;
         inReady   <= !next_skidValid;   // Full once the skid entry holds a word
      end
   end

endmodule : rlis_skid_buffer
`default_nettype wire

// ==== verification/rlis_line_input_chk.sv ====
// Port relation checker for the receive line input stage
`timescale 1ns/100ps
`default_nettype none
module rlis_line_input_chk
   import rlis_pkg::*;
(
   input wire logic         clock,
   input wire logic         rst_b,
   input wire logic         rxInterfaceSelect,
   input wire logic         rxRateSts3,
   input wire logic         byteRxClock,
   input wire logic         derivedRxByteClock,
   input wire rlis_word_t   rxWord,
   input wire logic         rxWordValid,
   input wire logic         rxWordReady,
   input wire logic         rxOverrun,
   input wire rlis_source_t rxSource
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   // Byte bus selected long enough to settle, then a byte clock edge
   sequence byteHeld;
      (!rxInterfaceSelect)[*6];
   endsequence
   sequence byteRise;
      byteHeld ##1 (!rxInterfaceSelect && $rose(byteRxClock));
   endsequence

   sel_byte_a: assert property (byteHeld |-> rxSource == SRC_BYTE)
      else $error("byte source not selected");
   sel_serial_a: assert property (rxInterfaceSelect[*6] |-> rxSource != SRC_BYTE)
      else $error("serial source not selected");
   ttl_sts1_a: assert property (rxRateSts3[*6] |-> rxSource != SRC_TTL)
      else $error("single-ended line used at the high rate");
   byte_answer_a: assert property (byteRise |-> ##[1:8] rxWordValid)
      else $error("no word after a byte clock edge");
   byte_noclk_a: assert property ((rxSource == SRC_BYTE)[*3] |-> !derivedRxByteClock)
      else $error("derived clock runs in byte mode");
   dclk_half_a: assert property ($rose(derivedRxByteClock) |->
      derivedRxByteClock[*8] or ##[0:7] !rxInterfaceSelect)
      else $error("derived clock high phase too short");
   word_hold_a: assert property (rxWordValid && !rxWordReady |=>
      rxWordValid && $stable(rxWord))
      else $error("word changed while stalled");
   serial_nofp_a: assert property (rxWordValid && rxWord.fromSerial |-> !rxWord.framePos)
      else $error("serial word carries a frame strobe");
   overrun_full_a: assert property (rxOverrun |-> $past(rxWordValid) && !$past(rxOverrun))
      else $error("overrun without a full buffer");
endmodule : rlis_line_input_chk
`default_nettype wire

// ==== verification/rlis_line_source.sv ====
// Far-side model: byte bus source and serial line source
`timescale 1ns/100ps
`default_nettype none
module rlis_line_source (
   input  wire logic       clock,
   input  wire logic       shortToDerived,
   input  wire logic       derivedRxByteClock,
   output var  logic       byteRxClock,
   output var  logic [7:0] byteRxBus,
   output var  logic       rxFramePosition,
   output var  logic       diffRxClock,
   output var  logic       diffRxData,
   output var  logic       ttlSerialRxClock,
   output var  logic       ttlSerialRxLine
);
   logic byteClk;

   // Byte clock input shorted to the derived clock in serial mode
   assign byteRxClock = shortToDerived ? derivedRxByteClock : byteClk;

   initial begin
      byteClk = 1'b0;
      byteRxBus = 8'h00;
      rxFramePosition = 1'b0;
      diffRxClock = 1'b0;
      diffRxData = 1'b0;
      ttlSerialRxClock = 1'b0;
      ttlSerialRxLine = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask : step

   // One scrambled byte, first line bit on the top line, held around the edge
   task automatic send_byte(input logic [7:0] d, input logic fp);
      byteRxBus = d;
      rxFramePosition = fp;
      step(2);
      byteClk = 1'b1;
      step(2);
      byteClk = 1'b0;
      step(1);
      byteRxBus = ~d; // Hold over, bus no longer shows the byte
      rxFramePosition = ~fp;
   endtask : send_byte

   // Eight bits, first bit first; the line clock stands still afterwards
   task automatic send_serial(input logic [7:0] d, input logic ttl);
      for (int i = 7; i >= 0; i--) begin
         diffRxData = ttl ? 1'b0 : d[i];
         ttlSerialRxLine = ttl ? d[i] : 1'b0;
         step(2);
         diffRxClock = !ttl;
         ttlSerialRxClock = ttl;
         step(2);
         diffRxClock = 1'b0;
         ttlSerialRxClock = 1'b0;
      end
      diffRxData = ~d[0];
      ttlSerialRxLine = 1'b0; // Pull-down level
   endtask : send_serial
endmodule : rlis_line_source
`default_nettype wire

// ==== verification/rlis_line_input_bench.sv ====
// Self-checking bench of the receive line input stage
`timescale 1ns/100ps
`default_nettype none
module rlis_line_input_bench
   import rlis_pkg::*;
;
   logic         clock, rst_b, rxInterfaceSelect, rxRateSts3, ttlSerialSelect, rxWordReady;
   logic         diffRxClock, diffRxData, ttlSerialRxClock, ttlSerialRxLine, byteRxClock;
   logic         rxFramePosition, derivedRxByteClock, rxWordValid, rxOverrun, stall, dPrev;
   logic [7:0]   byteRxBus;
   rlis_word_t   rxWord;
   rlis_source_t rxSource;
   rlis_word_t   expQ[$];
   int           miscompares, nChecks, nOverrun, nDclk;

   rlis_line_input u_rlis_line_input (.clock(clock), .rst_b(rst_b),
      .rxInterfaceSelect(rxInterfaceSelect), .rxRateSts3(rxRateSts3),
      .ttlSerialSelect(ttlSerialSelect), .diffRxClock(diffRxClock), .diffRxData(diffRxData),
      .ttlSerialRxClock(ttlSerialRxClock), .ttlSerialRxLine(ttlSerialRxLine),
      .byteRxClock(byteRxClock), .byteRxBus(byteRxBus), .rxFramePosition(rxFramePosition),
      .derivedRxByteClock(derivedRxByteClock), .rxWord(rxWord), .rxWordValid(rxWordValid),
      .rxWordReady(rxWordReady), .rxOverrun(rxOverrun), .rxSource(rxSource));

   rlis_line_source u_src (.clock(clock), .shortToDerived(rxInterfaceSelect),
      .derivedRxByteClock(derivedRxByteClock), .byteRxClock(byteRxClock),
      .byteRxBus(byteRxBus), .rxFramePosition(rxFramePosition), .diffRxClock(diffRxClock),
      .diffRxData(diffRxData), .ttlSerialRxClock(ttlSerialRxClock),
      .ttlSerialRxLine(ttlSerialRxLine));

   always #50 clock = ~clock;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (miscompares == 0 && nChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask : tick

   task automatic put_byte(input logic [7:0] d, input logic fp);
      expQ.push_back({d, fp, 1'b0, rxRateSts3});
      u_src.send_byte(d, fp);
      tick(4);
   endtask : put_byte

   task automatic put_serial(input logic [7:0] d, input logic ttl);
      expQ.push_back({d, 1'b0, 1'b1, rxRateSts3});
      u_src.send_serial(d, ttl);
      tick(4);
   endtask : put_serial

   task automatic select(input logic s, input logic r, input logic t, input rlis_source_t src);
      rxInterfaceSelect = s;
      rxRateSts3 = r;
      ttlSerialSelect = t;
      tick(10);
      check(16'(rxSource), 16'(src));
   endtask : select

   // Model: one expected word per accepted word, newest dropped on overrun
   always @(posedge clock) begin
      if (rst_b === 1'b1) begin
         if (rxWordValid === 1'b1 && rxWordReady === 1'b1) begin
            if (expQ.size() == 0) check(16'(rxWord), 16'hFFFF);
            else check(16'(rxWord), 16'(expQ.pop_front()));
         end
         if (rxOverrun === 1'b1) begin
            nOverrun++;
            if (expQ.size() != 0) void'(expQ.pop_back());
         end
         if (derivedRxByteClock === 1'b1 && dPrev === 1'b0) nDclk++;
         dPrev = derivedRxByteClock;
      end
   end

   // Downstream ready, random unless stalled
   always @(posedge clock) begin
      #10;
      rxWordReady = !stall && ($urandom % 4) != 0;
   end

   initial begin
      repeat (5000) @(posedge clock);
      miscompares++;
      wrap_up();
   end

   initial begin
      void'($urandom(9));
      {clock, rst_b, stall, rxWordReady, dPrev} = 5'h00;
      {rxInterfaceSelect, rxRateSts3, ttlSerialSelect} = 3'h0;
      tick(20);
      rst_b = 1'b1;
      check(16'({rxWordValid, rxOverrun, derivedRxByteClock, rxSource}), 16'h0);
      // Byte bus at both rates, bit order boundaries and a frame strobe
      for (int r = 0; r < 2; r++) begin
         select(1'b0, r[0], 1'b0, SRC_BYTE);
         put_byte(8'h80, 1'b0);
         put_byte(8'h01, 1'b1);
         for (int i = 0; i < 4; i++) put_byte(8'($urandom), 1'($urandom));
      end
      // Receiver stalls: two words kept, two refused; start from an empty buffer
      wait (expQ.size() == 0);
      tick(1);
      stall = 1'b1;
      tick(2);
      nOverrun = 0;
      repeat (4) put_byte(8'($urandom), 1'b0);
      check(16'(nOverrun), 16'h0002);
      stall = 1'b0;
      tick(30);
      check(16'(expQ.size()), 16'h0000);
      // Differential line at STS-3, single-ended request ignored
      select(1'b1, 1'b1, 1'b1, SRC_PECL);
      nDclk = 0;
      repeat (3) put_serial(8'($urandom), 1'b0);
      // First bit raises the derived clock, then every byte end raises it again
      check(16'(nDclk), 16'h0004);
      // Byte bus between serial modes, so the derived clock ends on the select pin
      select(1'b0, 1'b0, 1'b0, SRC_BYTE);
      // Single-ended line at STS-1
      select(1'b1, 1'b0, 1'b1, SRC_TTL);
      put_serial(8'h80, 1'b1);
      put_serial(8'($urandom), 1'b1);
      select(1'b0, 1'b0, 1'b0, SRC_BYTE);
      put_byte(8'hA5, 1'b1);
      tick(20);
      check(16'(expQ.size()), 16'h0000);
      wrap_up();
   end
endmodule : rlis_line_input_bench

bind rlis_line_input rlis_line_input_chk u_chk (.clock(clock), .rst_b(rst_b),
   .rxInterfaceSelect(rxInterfaceSelect), .rxRateSts3(rxRateSts3), .byteRxClock(byteRxClock),
   .derivedRxByteClock(derivedRxByteClock), .rxWord(rxWord), .rxWordValid(rxWordValid),
   .rxWordReady(rxWordReady), .rxOverrun(rxOverrun), .rxSource(rxSource));
`default_nettype wire
